// >>> verilog/cpsdp_pkg.sv
// Package for the codec PIO status and data port: constants and carrier types
package cpsdp_pkg;

  // ==========================================================
  // Widths and depths
  localparam int DATA_W = 8;    // One data port byte
  localparam int SAMPLE_W = 32; // Up to four bytes per sample or group
  localparam int IDX_W = 2;     // Byte index within a sample
  localparam int FIFO_DEPTH = 8; // Playback byte buffer depth
  localparam int LVL_W = 4;     // Width of a buffer level

  // ==========================================================
  // Values after reset and fixed answers
  localparam logic [7:0] IDLE_READ = 8'h80;     // Read value while idle
  localparam logic [1:0] IDX_RESET = 2'h0;      // First byte of a sample
  localparam logic [31:0] SAMPLE_RESET = 32'h0; // Empty sample
  localparam logic [3:0] LVL_FULL = 4'h8;       // Level of a full buffer

  // ==========================================================
  // Data format selection
  typedef struct packed {
    logic adpcm;  // Compressed four-byte groups
    logic pcm16;  // Two bytes per channel
    logic stereo; // Left then right
  } cpsdp_format_type;

  // Host-visible status bits
  typedef struct packed {
    logic play_ready;  // Room for playback data
    logic play_chan;   // Left/mono or first ADPCM half needed
    logic play_upper;  // Upper byte needed
    logic sample_err;  // Overrun or underrun seen
    logic cap_ready;   // Fresh capture byte waiting
    logic cap_chan;    // Left/mono or first ADPCM half available
    logic cap_upper;   // Upper byte available
  } cpsdp_status_type;

  // Alternate feature status: source of a sample error
  typedef struct packed {
    logic cap_overrun;   // Capture sample lost
    logic play_underrun; // Playback sample missing
  } cpsdp_alt_type;

  // Playback assembler states
  typedef enum logic [1:0] {
    ASM_FILL = 2'b01, // Collecting bytes from the buffer
    ASM_FULL = 2'b10  // Whole sample waiting for the converter
  } cpsdp_asm_type;

endpackage

// >>> verilog/cpsdp_fifo.sv
// Byte buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cpsdp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Occupancy
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  // ==========================================================
  // State
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage
    logic [PW-1:0] wr_ptr;            // Next slot to fill
    logic [PW-1:0] rd_ptr;            // Next slot to drain
    logic [CW-1:0] count;             // Words held
  } cpsdp_fifo_state_type;

  cpsdp_fifo_state_type s_q; // Registered state
  cpsdp_fifo_state_type s_d; // Next state
  logic push; // Word taken in
  logic pop;  // Word handed out

  // Handshake status straight from the count
  assign in_ready = (s_q.count != CW'(DEPTH));
  assign out_valid = (s_q.count != '0);
  assign out_data = s_q.mem[s_q.rd_ptr];
  assign level = s_q.count;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr_ptr] = in_data;
      s_d.wr_ptr = PW'((s_q.wr_ptr + 1'b1) % DEPTH);
    end
    if (pop) begin
      s_d.rd_ptr = PW'((s_q.rd_ptr + 1'b1) % DEPTH);
    end
    // Count moves only when one side acts alone
    if (push && !pop) begin
      s_d.count = s_q.count + 1'b1;
    end else if (pop && !push) begin
      s_d.count = s_q.count - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/cpsdp_port.sv
// Codec PIO status and shared sample data port
`timescale 1ns/1ps
`default_nettype none
module cpsdp_port (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host access to the shared data port
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [cpsdp_pkg::DATA_W-1:0] host_wdata,
  output logic [cpsdp_pkg::DATA_W-1:0] host_rdata,
  // Host clears of the error flags
  input wire logic status_clear,
  input wire logic alt_clear,
  // Status toward the host
  output cpsdp_pkg::cpsdp_status_type status,
  output cpsdp_pkg::cpsdp_alt_type alt_status,
  // Configuration
  input wire cpsdp_pkg::cpsdp_format_type fmt,
  input wire logic capture_enable,
  input wire logic playback_enable,
  input wire logic codec_idle,
  // Capture converter side
  input wire logic cap_valid,
  input wire logic [cpsdp_pkg::SAMPLE_W-1:0] cap_sample,
  // Playback converter side
  input wire logic play_tick,
  output logic [cpsdp_pkg::SAMPLE_W-1:0] play_sample,
  output logic play_strobe
);
  import cpsdp_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [SAMPLE_W-1:0] cap_bytes;  // Current capture sample
    logic [IDX_W-1:0] cap_idx;       // Byte the host reads next
    logic cap_fresh;                 // Unread bytes remain
    logic [IDX_W-1:0] play_wr_idx;   // Byte the host writes next
    logic [SAMPLE_W-1:0] asm_shift;  // Playback sample being built
    logic [IDX_W-1:0] asm_idx;       // Slot of next buffered byte
    cpsdp_asm_type asm_state;        // Assembler state
    logic [SAMPLE_W-1:0] play_out;   // Sample handed to converter
    logic play_stb;                  // Hand-over pulse
    logic [DATA_W-1:0] rdata;        // Last read answer
    cpsdp_status_type stat;          // Status bits
    cpsdp_alt_type alt;              // Error source bits
  } cpsdp_state_type;

  cpsdp_state_type s_q; // Registered state
  cpsdp_state_type s_d; // Next state

  // Buffer wiring
  logic fifo_in_valid;                // Accepted host write
  logic fifo_in_ready;                // Buffer has room
  logic fifo_out_valid;               // Byte waiting for assembler
  logic fifo_out_ready;               // Assembler takes a byte
  logic [DATA_W-1:0] fifo_out_data;   // Byte from buffer
  logic [LVL_W-1:0] fifo_level;       // Bytes buffered

  // Per-cycle events
  logic play_take;    // Host write enters buffer
  logic asm_pop;      // Assembler pulls a byte
  logic cap_overrun;  // Capture sample lost
  logic play_under;   // Converter found no sample
  logic [LVL_W-1:0] lvl_next; // Buffer level after this cycle

  // ==========================================================
  // Byte position helpers
  // Index of the last byte in a sample or group
  function automatic logic [IDX_W-1:0] last_idx(input cpsdp_format_type f);
    if (f.adpcm || (f.pcm16 && f.stereo)) begin
      last_idx = 2'h3;
    end else if (f.pcm16 || f.stereo) begin
      last_idx = 2'h1;
    end else begin
      last_idx = 2'h0;
    end
  endfunction

  // Channel flag for a byte index
  function automatic logic chan_flag(input logic [IDX_W-1:0] idx,
                                     input cpsdp_format_type f);
    if (f.adpcm) begin
      chan_flag = ~idx[1];
    end else if (!f.stereo) begin
      chan_flag = 1'b1;
    end else if (f.pcm16) begin
      chan_flag = ~idx[1];
    end else begin
      chan_flag = ~idx[0];
    end
  endfunction

  // Upper/lower flag for a byte index
  function automatic logic upper_flag(input logic [IDX_W-1:0] idx,
                                      input cpsdp_format_type f);
    if (f.adpcm || f.pcm16) begin
      upper_flag = idx[0];
    end else begin
      upper_flag = 1'b1;
    end
  endfunction

  // ==========================================================
  // Playback byte buffer
  cpsdp_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) i_cpsdp_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(host_wdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // Writes land in the playback path unless idle, disabled or the buffer is full
  assign play_take = host_wr && !codec_idle && playback_enable && fifo_in_ready;
  assign fifo_in_valid = play_take;
  // Assembler drains only while collecting, so the buffer fills
  assign fifo_out_ready = (s_q.asm_state == ASM_FILL);
  assign asm_pop = fifo_out_valid && fifo_out_ready;
  assign lvl_next = LVL_W'(fifo_level + LVL_W'(play_take) - LVL_W'(asm_pop));

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.play_stb = 1'b0;
    cap_overrun = 1'b0;
    play_under = 1'b0;

    // Host write advances playback byte position
    if (play_take) begin
      if (s_q.play_wr_idx >= last_idx(fmt)) begin
        s_d.play_wr_idx = IDX_RESET;
      end else begin
        s_d.play_wr_idx = s_q.play_wr_idx + 1'b1;
      end
    end

    // Host read of the capture side
    if (host_rd) begin
      if (codec_idle) begin
        s_d.rdata = IDLE_READ;
      end else begin
        s_d.rdata = s_q.cap_bytes[s_q.cap_idx*DATA_W +: DATA_W];
        // Step to next byte; stay on the last one
        if (s_q.cap_fresh) begin
          if (s_q.cap_idx >= last_idx(fmt)) begin
            s_d.cap_fresh = 1'b0;
          end else begin
            s_d.cap_idx = s_q.cap_idx + 1'b1;
          end
        end
      end
    end

    // New capture sample replaces the old one
    if (cap_valid && capture_enable && !codec_idle) begin
      cap_overrun = s_d.cap_fresh;
      s_d.cap_bytes = cap_sample;
      s_d.cap_idx = IDX_RESET;
      s_d.cap_fresh = 1'b1;
    end

    // Playback assembler
    unique case (s_q.asm_state)
      ASM_FILL: begin
        // Collect buffered bytes into the sample
        if (asm_pop) begin
          s_d.asm_shift[s_q.asm_idx*DATA_W +: DATA_W] = fifo_out_data;
          if (s_q.asm_idx >= last_idx(fmt)) begin
            s_d.asm_idx = IDX_RESET;
            s_d.asm_state = ASM_FULL;
          end else begin
            s_d.asm_idx = s_q.asm_idx + 1'b1;
          end
        end
        // Converter wanted a sample that is not complete
        if (play_tick && playback_enable) begin
          play_under = 1'b1;
        end
      end
      ASM_FULL: begin
        // Hand the whole sample over on the tick
        if (play_tick) begin
          s_d.play_out = s_q.asm_shift;
          s_d.play_stb = 1'b1;
          s_d.asm_shift = SAMPLE_RESET;
          s_d.asm_state = ASM_FILL;
        end
      end
      default: begin
        // Illegal code recovers to collecting
        s_d.asm_state = ASM_FILL;
      end
    endcase

    // Idle codec drops the unread capture bytes and the host write byte position
    if (codec_idle) begin
      s_d.cap_fresh = 1'b0;
      s_d.play_wr_idx = IDX_RESET;
    end

    // Shared error flag; a new error beats the clear
    if (status_clear) begin
      s_d.stat.sample_err = 1'b0;
    end
    if (cap_overrun || play_under) begin
      s_d.stat.sample_err = 1'b1;
    end

    // Separate source flags; a new error beats the clear
    if (alt_clear) begin
      s_d.alt = '0;
    end
    if (cap_overrun) begin
      s_d.alt.cap_overrun = 1'b1;
    end
    if (play_under) begin
      s_d.alt.play_underrun = 1'b1;
    end

    // Ready and position flags follow the next state
    s_d.stat.play_ready = playback_enable && !codec_idle && (lvl_next < LVL_FULL);
    s_d.stat.play_chan = chan_flag(s_d.play_wr_idx, fmt);
    s_d.stat.play_upper = upper_flag(s_d.play_wr_idx, fmt);
    s_d.stat.cap_ready = s_d.cap_fresh;
    s_d.stat.cap_chan = chan_flag(s_d.cap_idx, fmt);
    s_d.stat.cap_upper = upper_flag(s_d.cap_idx, fmt);
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.asm_state <= ASM_FILL;
      s_q.rdata <= IDLE_READ;
      s_q.stat.play_chan <= 1'b1;
      s_q.stat.cap_chan <= 1'b1;
      s_q.stat.play_upper <= 1'b1;
      s_q.stat.cap_upper <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs straight from the state register
  assign host_rdata = s_q.rdata;
  assign status = s_q.stat;
  assign alt_status = s_q.alt;
  assign play_sample = s_q.play_out;
  assign play_strobe = s_q.play_stb;
endmodule
`default_nettype wire

// >>> test/cpsdp_port_asserts.sv
// Checker for the codec PIO status and data port
`timescale 1ns/1ps
`default_nettype none
module cpsdp_port_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host side
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [cpsdp_pkg::DATA_W-1:0] host_rdata,
  input wire logic status_clear,
  input wire cpsdp_pkg::cpsdp_status_type status,
  input wire cpsdp_pkg::cpsdp_alt_type alt_status,
  // Configuration and converters
  input wire cpsdp_pkg::cpsdp_format_type fmt,
  input wire logic capture_enable,
  input wire logic playback_enable,
  input wire logic codec_idle,
  input wire logic cap_valid,
  input wire logic play_tick,
  input wire logic play_strobe
);
  import cpsdp_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==========
  // Assertions
  a_idle_read: assert property (host_rd && codec_idle |=> host_rdata == IDLE_READ)
    else $error("idle read not 80h");
  a_err_hold: assert property (status.sample_err && !status_clear |=> status.sample_err)
    else $error("sample error dropped");
  a_err_source: assert property ($rose(status.sample_err) |-> alt_status != 2'h0)
    else $error("error source missing");
  a_cap_fresh: assert property (cap_valid && capture_enable && !codec_idle |=> status.cap_ready)
    else $error("capture not fresh");
  a_ready_off: assert property (!playback_enable || codec_idle |=> !status.play_ready)
    else $error("playback ready while off");
  a_tick_result: assert property (play_tick && playback_enable |=> play_strobe || alt_status.play_underrun)
    else $error("tick gave no sample or error");
  a_byte_upper: assert property (!fmt.adpcm && !fmt.pcm16 ##1 $stable(fmt) |-> status.play_upper && status.cap_upper)
    else $error("8-bit byte flag low");
  a_mono_chan: assert property (!fmt.adpcm && !fmt.stereo ##1 $stable(fmt) |-> status.play_chan && status.cap_chan)
    else $error("mono channel flag low");
  a_wr_step: assert property (host_wr && status.play_ready && !codec_idle && fmt.pcm16 |=> $changed(status.play_upper))
    else $error("write did not advance");
  a_rd_step: assert property (host_rd && status.cap_ready && !cap_valid && fmt.pcm16 |=>
    $changed(status.cap_upper) || !status.cap_ready)
    else $error("read did not advance");
  // Main scenarios reached
  c_overrun: cover property ($rose(alt_status.cap_overrun));
  c_strobe: cover property (play_strobe);
  c_last_read: cover property (host_rd ##1 !status.cap_ready);
endmodule
bind cpsdp_port cpsdp_port_asserts i_cpsdp_port_asserts (.clk(clk), .rst(rst), .host_rd(host_rd),
  .host_wr(host_wr), .host_rdata(host_rdata), .status_clear(status_clear), .status(status),
  .alt_status(alt_status), .fmt(fmt), .capture_enable(capture_enable), .playback_enable(playback_enable),
  .codec_idle(codec_idle), .cap_valid(cap_valid), .play_tick(play_tick), .play_strobe(play_strobe));
`default_nettype wire

// >>> test/cpsdp_host.sv
// Host model: programmed-I/O reads and writes of the shared data port
`timescale 1ns/1ps
`default_nettype none
module cpsdp_host (
  // Clock
  input wire logic clk,
  // Data port strobes
  output logic host_rd,
  output logic host_wr,
  output logic [cpsdp_pkg::DATA_W-1:0] host_wdata,
  // Answers from the port
  input wire logic [cpsdp_pkg::DATA_W-1:0] host_rdata,
  input wire cpsdp_pkg::cpsdp_status_type status
);
  import cpsdp_pkg::*;
  initial begin
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_wdata = 8'h00;
  end
  // Write one byte once the port has room; gives up waiting after 50 cycles
  task automatic wr_byte(input logic [DATA_W-1:0] d);
    @(posedge clk);
    #1;
    for (int n = 0; n < 50 && status.play_ready !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    host_wr = 1'b1;
    host_wdata = d;
    @(posedge clk);
    #1;
    host_wr = 1'b0;
    host_wdata = ~d;
  endtask
  // Read one byte, paced on fresh data unless told to reread
  task automatic rd_byte(input logic pace, output logic [DATA_W-1:0] d);
    @(posedge clk);
    #1;
    for (int n = 0; n < 50 && pace && status.cap_ready !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    host_rd = 1'b1;
    @(posedge clk);
    #1;
    host_rd = 1'b0;
    // Answer already stands after the taking edge
    d = host_rdata;
  endtask
endmodule
`default_nettype wire

// >>> test/cpsdp_port_tb.sv
// Self-checking bench for the codec PIO status and data port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    n_checks++; \
    if ((got) !== (ex)) begin \
      $display("wrong value %s expected %h seen %h", nm, ex, got); \
      n_errors++; \
    end \
  end
module cpsdp_port_tb;
  import cpsdp_pkg::*;
  // ==========
  // Bench signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic host_rd;
  logic host_wr;
  logic status_clear = 1'b0;
  logic alt_clear = 1'b0;
  logic codec_idle = 1'b0;
  logic cap_valid = 1'b0;
  logic play_tick = 1'b0;
  logic cap_en = 1'b1;  // Capture path enable
  logic play_en = 1'b1; // Playback path enable
  logic play_strobe;
  logic [DATA_W-1:0] host_wdata;
  logic [DATA_W-1:0] host_rdata;
  logic [SAMPLE_W-1:0] play_sample;
  cpsdp_status_type status;
  cpsdp_alt_type alt_status;
  cpsdp_format_type fmt = 3'h0;
  cpsdp_format_type fmts [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
  int n_errors = 0;
  int n_checks = 0;
  always #4 clk = ~clk;
  // ==========
  // Block and host model
  cpsdp_port i_cpsdp_port (.clk(clk), .rst(rst), .host_rd(host_rd), .host_wr(host_wr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .status_clear(status_clear), .alt_clear(alt_clear),
    .status(status), .alt_status(alt_status), .fmt(fmt), .capture_enable(cap_en), .playback_enable(play_en),
    .codec_idle(codec_idle), .cap_valid(cap_valid), .cap_sample(32'h44332211), .play_tick(play_tick),
    .play_sample(play_sample), .play_strobe(play_strobe));
  cpsdp_host i_cpsdp_host (.clk(clk), .host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .status(status));
  // ==========
  // Expected byte order
  function automatic int nbytes(input cpsdp_format_type f);
    return f.adpcm ? 4 : (f.pcm16 ? 2 : 1) << f.stereo;
  endfunction
  // Channel and byte flags for byte i
  function automatic logic [1:0] flags(input cpsdp_format_type f, input int i);
    logic c;
    c = (!f.adpcm && !f.stereo) || i < nbytes(f) / 2;
    return {c, (f.adpcm || f.pcm16) ? i[0] : 1'b1};
  endfunction
  // One-cycle pulse taken at the next edge
  task automatic pulse(ref logic s);
    @(posedge clk);
    #1;
    s = 1'b1;
    @(posedge clk);
    #1;
    s = 1'b0;
  endtask
  // ==========
  // Scenarios
  task automatic t_cap(input cpsdp_format_type f);
    logic [7:0] d;
    fmt = f;
    pulse(cap_valid);
    for (int i = 0; i < nbytes(f); i++) begin
      `CHK("cap_ready", 1'b1, status.cap_ready)
      `CHK("cap_pos", flags(f, i), {status.cap_chan, status.cap_upper})
      i_cpsdp_host.rd_byte(1'b1, d);
      `CHK("cap_byte", 8'(8'h11 * (i + 1)), d)
    end
    `CHK("cap_stale", 1'b0, status.cap_ready)
    i_cpsdp_host.rd_byte(1'b0, d);
    `CHK("cap_hold", 8'(8'h11 * nbytes(f)), d)
    $display("test capture fmt %h done", f);
  endtask
  task automatic t_play(input cpsdp_format_type f);
    logic [31:0] s;
    logic [31:0] m;
    fmt = f;
    s = '0;
    m = '0;
    repeat (2) @(posedge clk);
    #1;
    for (int i = 0; i <= nbytes(f); i++) begin
      `CHK("play_pos", flags(f, i % nbytes(f)), {status.play_chan, status.play_upper})
      if (i < nbytes(f)) begin
        s[8*i +: 8] = 8'hA0 + 8'(i);
        m[8*i +: 8] = 8'hFF;
        i_cpsdp_host.wr_byte(s[8*i +: 8]);
      end
    end
    repeat (8) @(posedge clk);
    pulse(play_tick);
    `CHK("strobe", 1'b1, play_strobe)
    `CHK("sample", s, play_sample & m)
    $display("test playback fmt %h done", f);
  endtask
  task automatic t_err;
    pulse(cap_valid);
    pulse(cap_valid);
    `CHK("overrun", 3'h6, {status.sample_err, alt_status})
    pulse(status_clear);
    `CHK("err_clear", 3'h2, {status.sample_err, alt_status})
    pulse(alt_clear);
    pulse(play_tick);
    `CHK("underrun", 3'h5, {status.sample_err, alt_status})
    pulse(status_clear);
    // New overrun and clear in one cycle: the set wins
    @(posedge clk);
    #1;
    cap_valid = 1'b1;
    status_clear = 1'b1;
    @(posedge clk);
    #1;
    cap_valid = 1'b0;
    status_clear = 1'b0;
    `CHK("set_wins", 1'b1, status.sample_err)
    pulse(status_clear);
    pulse(alt_clear);
    $display("test errors done");
  endtask
  task automatic t_idle;
    logic [7:0] d;
    fmt = 3'h0;
    codec_idle = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK("idle_ready", 2'h0, {status.play_ready, status.cap_ready})
    i_cpsdp_host.rd_byte(1'b0, d);
    `CHK("idle_read", 8'h80, d)
    i_cpsdp_host.wr_byte(8'h5A);
    pulse(cap_valid);
    codec_idle = 1'b0;
    pulse(play_tick);
    `CHK("idle_write", 1'b0, play_strobe)
    `CHK("idle_cap", 1'b0, status.cap_ready)
    $display("test idle done");
  endtask
  // Disabled paths: no ready, no capture, no underrun, writes dropped
  task automatic t_off;
    cap_en = 1'b0;
    play_en = 1'b0;
    pulse(status_clear);
    pulse(alt_clear);
    `CHK("off_ready", 1'b0, status.play_ready)
    pulse(cap_valid);
    `CHK("off_cap", 1'b0, status.cap_ready)
    pulse(play_tick);
    `CHK("off_tick", 3'h0, {status.sample_err, alt_status})
    i_cpsdp_host.wr_byte(8'h3C);
    cap_en = 1'b1;
    play_en = 1'b1;
    pulse(play_tick);
    `CHK("off_write", 1'b0, play_strobe)
    pulse(status_clear);
    pulse(alt_clear);
    $display("test disabled paths done");
  endtask
  // ==========
  // Verdict
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #50000;
    n_errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    `CHK("rst_rdata", 8'h80, host_rdata)
    `CHK("rst_status", 7'h33, status)
    `CHK("rst_alt", 2'h0, alt_status)
    #1;
    rst = 1'b0;
    $display("test reset done");
    foreach (fmts[k]) t_cap(fmts[k]);
    foreach (fmts[k]) t_play(fmts[k]);
    t_err();
    t_idle();
    t_off();
    end_sim();
  end
endmodule
`default_nettype wire
